// File: unr_top.sv
// unr_top: 1 kbit user nonvolatile store with a byte read port for core
// logic and a bank-wide programming port for the test-access controller.
// assumes: the programming port is driven, already deciphered, by the
// test-access programming controller running on i_core_clk.
//
// Overview of operation
// - store holds eight banks of 128 bits, one kilobit in all.
// - core reads return one byte per access, clocked by core clock.
// - top three address bits select one of the eight banks.
// - low four address bits select one of sixteen bytes in bank.
// - core has no write or erase path; contents stay unchanged.
// - contents readable through programming port and by core addressing.
// - erase and write accepted only through the programming port.
// - ciphered loads are decrypted on chip, except on smallest variants.
`timescale 1ns/1ps
`default_nettype none
module unr_top
    import unr_pkg::*;
#(
    parameter bit HAS_DECRYPT = 1'b1
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_arst_n,
    input  wire unr_rd_req_s          i_rd_req,
    output logic [7:0]                o_rd_data,
    output logic                      o_rd_valid,
    input  wire unr_pg_req_s          i_pg_req,
    input  wire logic [BANK_BITS-1:0] i_pg_plain,
    output logic [BANK_BITS-1:0]      o_pg_rdata,
    output logic                      o_pg_done,
    output logic                      o_pg_refused
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    unr_state_s st_reg;
    unr_state_s st_next;
    logic       pg_ok;
    logic [BANK_BITS-1:0] load_data;

    // ciphered load gate
    // a variant without the decipher path cannot trust the payload, so
    // the load is refused rather than storing scrambled bytes
    assign pg_ok     = i_pg_req.valid &&
                       (!i_pg_req.ciphered || HAS_DECRYPT);
    assign load_data = i_pg_req.ciphered ? i_pg_plain : i_pg_req.data;

    always_comb begin
        st_next            = st_reg;
        st_next.rd_valid   = 1'b0;
        st_next.pg_done    = 1'b0;
        st_next.pg_refused = 1'b0;
        if (i_rd_req.en) begin
            st_next.rd_data  = st_reg.store[unr_bank_of(i_rd_req.addr)]
                                           [unr_byte_of(i_rd_req.addr)];
            st_next.rd_valid = 1'b1;
        end
        if (i_pg_req.valid && !pg_ok) begin
            st_next.pg_refused = 1'b1;
        end else if (pg_ok) begin
            st_next.pg_done = 1'b1;
            case (i_pg_req.op)
                UNR_PG_READ: begin
                    st_next.pg_rdata = st_reg.store[i_pg_req.bank];
                end
                UNR_PG_ERASE: begin
                    st_next.store[i_pg_req.bank] =
                        {BYTES_PER_BANK{ERASED_BYTE}};
                end
                UNR_PG_WRITE: begin
                    st_next.store[i_pg_req.bank] = load_data;
                end
                default: begin
                    st_next.pg_done    = 1'b0;
                    st_next.pg_refused = 1'b1;
                end
            endcase
        end
    end

    // eight by 128 bits
    // the array resets to the erased pattern; a real flash keeps its
    // contents, this model only keeps them while reset stays released
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{store: {(NUM_BANKS*BYTES_PER_BANK){ERASED_BYTE}},
                        rd_data: 8'h00, rd_valid: 1'b0,
                        pg_rdata: '0, pg_done: 1'b0, pg_refused: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rd_data    = st_reg.rd_data;
    assign o_rd_valid   = st_reg.rd_valid;
    assign o_pg_rdata   = st_reg.pg_rdata;
    assign o_pg_done    = st_reg.pg_done;
    assign o_pg_refused = st_reg.pg_refused;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    rd_latency_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        i_rd_req.en |=> o_rd_valid)
        else $error("read valid did not follow request");

    rd_idle_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        !i_rd_req.en |=> !o_rd_valid)
        else $error("read valid without request");

    rd_byte_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        i_rd_req.en |=> o_rd_data ==
            $past(st_reg.store[i_rd_req.addr[6:4]][i_rd_req.addr[3:0]]))
        else $error("read byte does not match addressed location");

    rd_hold_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        !i_rd_req.en |=> $stable(o_rd_data))
        else $error("read data moved without request");

    store_guard_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        !(pg_ok && i_pg_req.op != UNR_PG_READ) |=> $stable(st_reg.store))
        else $error("store changed without programming");

    pg_erase_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        (pg_ok && i_pg_req.op == UNR_PG_ERASE) |=>
            st_reg.store[$past(i_pg_req.bank)] == {16{ERASED_BYTE}} &&
            o_pg_done)
        else $error("bank erase not applied");

    pg_write_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        (pg_ok && i_pg_req.op == UNR_PG_WRITE) |=>
            st_reg.store[$past(i_pg_req.bank)] == $past(load_data))
        else $error("bank write not applied");

    pg_readback_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        (pg_ok && i_pg_req.op == UNR_PG_READ) |=>
            o_pg_rdata == $past(st_reg.store[i_pg_req.bank]))
        else $error("programming readback mismatch");

    pg_cipher_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        (i_pg_req.valid && i_pg_req.ciphered && !HAS_DECRYPT) |=>
            o_pg_refused && !o_pg_done)
        else $error("ciphered load not refused");

    pg_idle_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        !i_pg_req.valid |=> !o_pg_done && !o_pg_refused)
        else $error("programming answer without request");

    pg_single_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        !(o_pg_done && o_pg_refused))
        else $error("programming accepted and refused at once");

    pg_accept_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        (pg_ok && i_pg_req.op inside {UNR_PG_READ, UNR_PG_ERASE,
            UNR_PG_WRITE}) |=> o_pg_done && !o_pg_refused)
        else $error("legal programming request not accepted");

    pg_illegal_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        (i_pg_req.valid && !(i_pg_req.op inside {UNR_PG_READ,
            UNR_PG_ERASE, UNR_PG_WRITE})) |=>
            o_pg_refused && !o_pg_done && $stable(st_reg.store))
        else $error("illegal programming code not refused");

    refuse_keep_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        o_pg_refused |-> $stable(st_reg.store))
        else $error("refused request changed the store");

    plain_load_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        (pg_ok && i_pg_req.op == UNR_PG_WRITE && !i_pg_req.ciphered) |=>
            st_reg.store[$past(i_pg_req.bank)] == $past(i_pg_req.data))
        else $error("plain write payload not stored");

    cipher_load_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        (pg_ok && i_pg_req.op == UNR_PG_WRITE && i_pg_req.ciphered) |=>
            st_reg.store[$past(i_pg_req.bank)] == $past(i_pg_plain))
        else $error("deciphered payload not stored");

    rdata_hold_a: assert property (
        @(posedge i_core_clk) disable iff (!rst_n)
        !(pg_ok && i_pg_req.op == UNR_PG_READ) |=> $stable(o_pg_rdata))
        else $error("readback data moved without readback");

endmodule : unr_top
`default_nettype wire

// File: unr_pkg.sv
// unr_pkg: constants and carrier types for the user nonvolatile byte store.
// assumes: one core clock; the programming controller shares that clock.
package unr_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int unsigned NUM_BANKS      = 8;
    localparam int unsigned BANK_BITS      = 128;
    localparam int unsigned BYTES_PER_BANK = BANK_BITS / 8;
    localparam int unsigned ADDR_W         = 7;
    localparam int unsigned BANK_W         = 3;
    localparam int unsigned BYTE_W         = 4;
    localparam int unsigned BANK_LSB       = 4;
    localparam int unsigned BYTE_LSB       = 0;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef logic [NUM_BANKS-1:0][BYTES_PER_BANK-1:0][7:0] unr_store_t;

    typedef struct packed {
        logic                 en;
        logic [ADDR_W-1:0]    addr;
    } unr_rd_req_s;

    typedef enum logic [1:0] {
        UNR_PG_READ  = 2'b00,
        UNR_PG_ERASE = 2'b01,
        UNR_PG_WRITE = 2'b10
    } unr_pg_op_e;

    typedef struct packed {
        logic                 valid;
        unr_pg_op_e           op;
        logic [BANK_W-1:0]    bank;
        logic                 ciphered;
        logic [BANK_BITS-1:0] data;
    } unr_pg_req_s;

    typedef struct packed {
        unr_store_t           store;
        logic [7:0]           rd_data;
        logic                 rd_valid;
        logic [BANK_BITS-1:0] pg_rdata;
        logic                 pg_done;
        logic                 pg_refused;
    } unr_state_s;

    // ----------------------------------------------------------------
    // address decoding
    // ----------------------------------------------------------------
    function automatic logic [BANK_W-1:0] unr_bank_of(
        input logic [ADDR_W-1:0] a);
        return a[BANK_LSB +: BANK_W];
    endfunction : unr_bank_of

    function automatic logic [BYTE_W-1:0] unr_byte_of(
        input logic [ADDR_W-1:0] a);
        return a[BYTE_LSB +: BYTE_W];
    endfunction : unr_byte_of

endpackage : unr_pkg

// File: unr_core_side.sv
// unr_core_side: core-fabric user logic that issues byte reads.
// assumes: i_go and i_addr change just after a rising core clock edge.
`timescale 1ns/1ps
`default_nettype none
module unr_core_side
    import unr_pkg::*;
(
    input  wire logic              i_go,
    input  wire logic [ADDR_W-1:0] i_addr,
    output unr_rd_req_s            o_req
);
    logic [ADDR_W-1:0] last_addr;
    always_latch begin
        if (i_go) last_addr <= i_addr;
    end
    // seven-bit address
    // idle port shows the inverted last address, never a held copy
    assign o_req.en   = i_go;
    assign o_req.addr = i_go ? i_addr : ~last_addr;
endmodule : unr_core_side
`default_nettype wire

// File: unr_top_bench.sv
// unr_top_bench: self-checking bench for the user nonvolatile byte store.
// assumes: unr_core_side drives reads, the bench drives programming.
`timescale 1ns/1ps
`default_nettype none
module unr_top_bench
    import unr_pkg::*;
;
    logic                 clk = 1'b0;
    logic                 arst_n = 1'b0;
    logic                 go = 1'b0;
    logic [ADDR_W-1:0]    addr = '0;
    unr_rd_req_s          rd_req;
    unr_pg_req_s          pg_req = '0;
    logic [BANK_BITS-1:0] plain = '0;
    logic [BANK_BITS-1:0] rb = '0;
    logic [BANK_BITS-1:0] pg_rdata;
    logic [7:0]           rd_data;
    logic                 rd_valid, pg_done, pg_refused;
    logic [1:0]           sm_ans;
    logic [1:0]           sq [$];
    logic [BANK_BITS-1:0] mem [NUM_BANKS];
    logic [7:0]           rq [$];
    logic [BANK_BITS+1:0] pq [$];
    int                   failures = 0;
    int                   n_tests = 0;
    always #4 clk = ~clk;
    unr_core_side side (.i_go(go), .i_addr(addr), .o_req(rd_req));
    unr_top uut (.i_core_clk(clk), .i_arst_n(arst_n), .i_rd_req(rd_req),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_pg_req(pg_req),
        .i_pg_plain(plain), .o_pg_rdata(pg_rdata), .o_pg_done(pg_done),
        .o_pg_refused(pg_refused));
    // smallest variant: ciphered loads must be refused, plain ones taken
    unr_top #(.HAS_DECRYPT(1'b0)) uut_small (.i_core_clk(clk),
        .i_arst_n(arst_n), .i_rd_req(rd_req), .o_rd_data(),
        .o_rd_valid(), .i_pg_req(pg_req), .i_pg_plain(plain),
        .o_pg_rdata(), .o_pg_done(sm_ans[1]), .o_pg_refused(sm_ans[0]));
    task automatic check(input string what,
        input logic [BANK_BITS+1:0] seen, input logic [BANK_BITS+1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [BANK_BITS-1:0] rnd128();
        return {$urandom(), $urandom(), $urandom(), $urandom()};
    endfunction : rnd128
    // read port is driven every cycle while go stays high
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        #1;
        go = 1'b1;
        addr = a;
        rq.push_back(mem[a[6:4]][a[3:0]*8 +: 8]);
    endtask : rd
    task automatic rd_stop();
        @(posedge clk);
        #1;
        go = 1'b0;
    endtask : rd_stop
    task automatic pg(input logic [1:0] op, input logic [2:0] b,
        input logic c, input logic [BANK_BITS-1:0] d);
        @(posedge clk);
        #1;
        plain = rnd128();
        pg_req = '{1'b1, unr_pg_op_e'(op), b, c, d};
        sq.push_back((op == 2'b11 || c) ? 2'b01 : 2'b10);
        if (op == 2'b11) pq.push_back({2'b01, rb});
        else begin
            if (op == 2'b01) mem[b] = {BYTES_PER_BANK{ERASED_BYTE}};
            if (op == 2'b10) mem[b] = c ? plain : d;
            if (op == 2'b00) rb = mem[b];
            pq.push_back({2'b10, rb});
        end
        @(posedge clk);
        #1;
        pg_req.valid = 1'b0;
    endtask : pg
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (rq.size() == 0) check("read pulse", 1, 0);
            else check("read byte", rd_data, rq.pop_front());
        end
        if ((pg_done | pg_refused) === 1'b1) begin
            if (pq.size() == 0) check("program pulse", 1, 0);
            else check("program", {pg_done, pg_refused, pg_rdata},
                pq.pop_front());
        end
        if ((|sm_ans) === 1'b1) begin
            if (sq.size() == 0) check("small pulse", 1, 0);
            else check("small", sm_ans, sq.pop_front());
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial begin
        void'($urandom(32'h356de898));
        for (int b = 0; b < NUM_BANKS; b++) mem[b] = '1;
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("reset byte", rd_data, 8'h00);
        check("reset pulses", {rd_valid, pg_done, pg_refused}, 0);
        check("reset readback", pg_rdata, 0);
        // erased store, corner addresses
        for (int a = 0; a < 128; a += 15) rd(a[6:0]);
        rd(7'h7F);
        rd_stop();
        $display("test erased done");
        // odd banks take the deciphered payload
        for (int b = 0; b < 8; b++) pg(2'b10, b[2:0], b[0], rnd128());
        for (int a = 0; a < 128; a++) rd(a[6:0]);
        rd_stop();
        $display("test write all done");
        pg(2'b00, 3'd3, 1'b0, rnd128());
        pg(2'b01, 3'd3, 1'b0, rnd128());
        pg(2'b11, 3'd5, 1'b0, rnd128());
        pg(2'b00, 3'd3, 1'b0, rnd128());
        pg(2'b00, 3'd5, 1'b0, rnd128());
        rd(7'h35);
        rd(7'h5F);
        rd_stop();
        for (int i = 0; i < 10 && rq.size() + pq.size() + sq.size() > 0; i++)
            @(posedge clk);
        if (rq.size() + pq.size() + sq.size() > 0)
            check("pending", 1, 0);
        $display("test program ops done");
        test_done();
    end
endmodule : unr_top_bench
`default_nettype wire
